/* hdl/lbox_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module lbox_exec (
	// Clock and reset
	input  wire logic                        clock,
	input  wire logic                        rst,
	// Fetch stage
	input  wire logic                        insn_valid,
	input  wire logic [lbox_pkg::INSN_W-1:0] insn,
	output var  logic                        insn_done,
	output var  logic                        skip_cycle,
	// File register space
	output var  logic [lbox_pkg::ADDR_W-1:0] file_raddr,
	input  wire logic [lbox_pkg::DATA_W-1:0] file_rdata,
	output var  logic                        file_we,
	output var  logic [lbox_pkg::ADDR_W-1:0] file_waddr,
	output var  logic [lbox_pkg::DATA_W-1:0] file_wdata,
	// Core state
	output var  logic [lbox_pkg::DATA_W-1:0] work_reg,
	output var  logic                        zero_flag
);
	import lbox_pkg::*;

	typedef enum logic {LBOX_RUN, LBOX_DEAD} lbox_state_e;

	typedef struct packed {
		lbox_state_e                 st;
		logic                        done;
		logic                        skip;
		logic                        we;
		logic [ADDR_W-1:0]           waddr;
		logic [DATA_W-1:0]           wdata;
		logic [DATA_W-1:0]           w;
		logic                        z;
	} lbox_state_s;

	lbox_state_s r;
	lbox_state_s next_r;
	lbox_dec_if  dif ();
	logic [DATA_W-1:0] bit_mask;
	logic [DATA_W-1:0] and_res;

	lbox_decode u_dec (
		.d (dif.dec)
	);

	// Fetch word goes to the decoder; file read address is combinational
	assign dif.insn   = insn;
	assign file_raddr = dif.addr;
	assign bit_mask   = 8'h01 << dif.sel;
	assign and_res    = work_reg & (dif.op == LBOX_OP_ANDL ? dif.lit : file_rdata);

	// Next-state logic; file read is same-cycle so each op is one cycle, except a bit test with the bit clear, which adds a dead cycle
	always_comb begin
		next_r      = r;
		next_r.done = 1'b0;
		next_r.skip = 1'b0;
		next_r.we   = 1'b0;
		case (r.st)
			LBOX_RUN: begin
				if (insn_valid) begin
					next_r.done = 1'b1;
					case (dif.op)
						LBOX_OP_CLEAR: begin
							next_r.we    = 1'b1;
							next_r.waddr = dif.addr;
							next_r.wdata = file_rdata & ~bit_mask;
						end
						LBOX_OP_SET: begin
							next_r.we    = 1'b1;
							next_r.waddr = dif.addr;
							next_r.wdata = file_rdata | bit_mask;
						end
						LBOX_OP_TEST: begin
							// Bit clear: a second cycle follows
							if ((file_rdata & bit_mask) == ZERO_B) begin
								next_r.st = LBOX_DEAD;
							end
						end
						LBOX_OP_ANDL: begin
							next_r.w = and_res;
							next_r.z = (and_res == ZERO_B);
						end
						LBOX_OP_ANDF: begin
							next_r.z = (and_res == ZERO_B);
							if (dif.dest_file) begin
								next_r.we    = 1'b1;
								next_r.waddr = dif.addr;
								next_r.wdata = and_res;
							end else begin
								next_r.w = and_res;
							end
						end
						default: begin
							next_r.done = 1'b1;
						end
					endcase
				end
			end
			LBOX_DEAD: begin
				// Prefetched word is consumed without effect
				next_r.st   = LBOX_RUN;
				next_r.skip = 1'b1;
				next_r.done = 1'b0;
			end
			default: begin
				next_r.st = LBOX_RUN;
			end
		endcase
	end

	// Single state register
	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			r <= '{st: LBOX_RUN, done: 1'b0, skip: 1'b0, we: 1'b0,
				waddr: '0, wdata: ZERO_B, w: W_RESET, z: 1'b0};
		end else begin
			r <= next_r;
		end
	end

	// Outputs straight from the state register
	assign insn_done  = r.done;
	assign skip_cycle = r.skip;
	assign file_we    = r.we;
	assign file_waddr = r.waddr;
	assign file_wdata = r.wdata;
	assign work_reg   = r.w;
	assign zero_flag  = r.z;

	// A taken skip is exactly one dead cycle, then normal flow
	a_skip_one_cycle: assert property (@(posedge clock) disable iff (rst)
		(r.st == LBOX_DEAD) |=> skip_cycle && !file_we && (r.st == LBOX_RUN))
		else $error("skip cycle not single");

	// During the dead cycle nothing changes
	a_dead_no_effect: assert property (@(posedge clock) disable iff (rst)
		skip_cycle |-> !file_we && $stable(work_reg) && $stable(zero_flag))
		else $error("no-op cycle changed state");

	// Bit-test path, split by the value of the tested bit
	sequence s_test_clear;
		insn_valid && r.st == LBOX_RUN && dif.op == LBOX_OP_TEST && file_rdata[dif.sel] == 1'b0;
	endsequence
	sequence s_test_set;
		insn_valid && r.st == LBOX_RUN && dif.op == LBOX_OP_TEST && file_rdata[dif.sel] == 1'b1;
	endsequence

	// Word offered while the dead state holds; it must be dropped
	sequence s_dead_fetch;
		insn_valid && r.st == LBOX_DEAD;
	endsequence

	// Bit clear and bit set accepted in normal flow
	sequence s_clear_op;
		insn_valid && r.st == LBOX_RUN && dif.op == LBOX_OP_CLEAR;
	endsequence
	sequence s_set_op;
		insn_valid && r.st == LBOX_RUN && dif.op == LBOX_OP_SET;
	endsequence

	// Clear bit: done pulse, then the dead cycle
	a_test_skip: assert property (@(posedge clock) disable iff (rst)
		s_test_clear |=> insn_done ##1 skip_cycle)
		else $error("clear bit did not skip");

	// Set bit: done pulse, straight back to normal flow
	a_test_noskip: assert property (@(posedge clock) disable iff (rst)
		s_test_set |=> insn_done && r.st == LBOX_RUN)
		else $error("set bit skipped");

	// Opcode and address field of the test word
	a_test_decode: assert property (@(posedge clock) disable iff (rst)
		(insn[13:10] == OP_BIT_TEST_CL) |-> dif.op == LBOX_OP_TEST && dif.addr == insn[6:0])
		else $error("test opcode misdecoded");

	// Clear forces only the chosen bit low; flags untouched
	a_bit_clear: assert property (@(posedge clock) disable iff (rst)
		s_clear_op |=> file_we && file_wdata == ($past(file_rdata) & ~(8'h01 << $past(dif.sel)))
		&& $stable(zero_flag))
		else $error("bit clear wrong");

	// Set forces only the chosen bit high
	a_bit_set: assert property (@(posedge clock) disable iff (rst)
		s_set_op |=> file_we && file_waddr == $past(dif.addr)
		&& file_wdata == ($past(file_rdata) | (8'h01 << $past(dif.sel))))
		else $error("bit set wrong");

	// Clear lands at the addressed register and spares W
	a_clear_target: assert property (@(posedge clock) disable iff (rst)
		s_clear_op |=> file_we && file_waddr == $past(dif.addr) && $stable(work_reg))
		else $error("bit clear target wrong");

	// Set leaves W and the zero flag alone
	a_set_keeps_flags: assert property (@(posedge clock) disable iff (rst)
		s_set_op |=> $stable(work_reg) && $stable(zero_flag))
		else $error("bit set changed core state");

	// An untaken test writes nothing; the next word may write later
	a_test_no_write: assert property (@(posedge clock) disable iff (rst)
		s_test_set |=> !file_we)
		else $error("test wrote a register");

	// A taken test and its dead cycle write nothing
	a_skip_no_write: assert property (@(posedge clock) disable iff (rst)
		s_test_clear |=> !file_we ##1 !file_we)
		else $error("skipped word wrote a register");

	// Discarded word never executes, so none of its effects appear
	a_dead_drops_word: assert property (@(posedge clock) disable iff (rst)
		s_dead_fetch |=> !insn_done && !file_we && $stable(work_reg) && $stable(zero_flag))
		else $error("discarded word was executed");

	// Skip marker only follows the dead state, never a stray pulse
	a_skip_from_dead: assert property (@(posedge clock) disable iff (rst)
		skip_cycle |-> $past(r.st) == LBOX_DEAD)
		else $error("skip marker without a taken test");
endmodule
`default_nettype wire

/* hdl/lbox_pkg.sv */
package lbox_pkg;
	// Instruction word layout (14-bit)
	localparam int INSN_W       = 14;
	localparam int DATA_W       = 8;
	localparam int ADDR_W       = 7;
	localparam int SEL_W        = 3;
	localparam int ADDR_LSB     = 0;
	localparam int SEL_LSB      = 7;
	localparam int DEST_BIT     = 7;
	// Opcode top bits
	localparam logic [3:0] OP_BIT_CLEAR   = 4'h4; // 01 00
	localparam logic [3:0] OP_BIT_SET     = 4'h5; // 01 01
	localparam logic [3:0] OP_BIT_TEST_CL = 4'h6; // 01 10
	localparam logic [5:0] OP_AND_LIT     = 6'h39; // 11 1001
	localparam logic [5:0] OP_AND_FILE    = 6'h05; // 00 0101
	localparam logic [DATA_W-1:0] W_RESET = 8'h00;
	localparam logic [DATA_W-1:0] ZERO_B  = 8'h00;
	// Operation classes
	typedef enum logic [2:0] {
		LBOX_OP_NONE,
		LBOX_OP_CLEAR,
		LBOX_OP_SET,
		LBOX_OP_TEST,
		LBOX_OP_ANDL,
		LBOX_OP_ANDF
	} lbox_op_e;
endpackage

/* hdl/lbox_dec_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface lbox_dec_if;
	import lbox_pkg::*;
	logic [lbox_pkg::INSN_W-1:0] insn;
	lbox_op_e                    op;
	logic [lbox_pkg::ADDR_W-1:0] addr;
	logic [lbox_pkg::SEL_W-1:0]  sel;
	logic                        dest_file;
	logic [lbox_pkg::DATA_W-1:0] lit;
	modport dec (input insn, output op, output addr, output sel, output dest_file, output lit);
	modport core (output insn, input op, input addr, input sel, input dest_file, input lit);
endinterface
`default_nettype wire

/* hdl/lbox_decode.sv */
`timescale 1ns/1ps
`default_nettype none
module lbox_decode (
	// Decode carrier
	lbox_dec_if.dec d
);
	import lbox_pkg::*;
	// Pure decode of the field layout
	always_comb begin
		d.addr      = d.insn[ADDR_LSB +: ADDR_W];
		d.sel       = d.insn[SEL_LSB +: SEL_W];
		d.dest_file = d.insn[DEST_BIT];
		d.lit       = d.insn[DATA_W-1:0];
		d.op        = LBOX_OP_NONE;
		if (d.insn[13:10] == OP_BIT_CLEAR) begin
			d.op = LBOX_OP_CLEAR;
		end else if (d.insn[13:10] == OP_BIT_SET) begin
			d.op = LBOX_OP_SET;
		end else if (d.insn[13:10] == OP_BIT_TEST_CL) begin
			d.op = LBOX_OP_TEST;
		end else if (d.insn[13:8] == OP_AND_LIT) begin
			d.op = LBOX_OP_ANDL;
		end else if (d.insn[13:8] == OP_AND_FILE) begin
			d.op = LBOX_OP_ANDF;
		end
	end
endmodule
`default_nettype wire

/* tb/lbox_file_model.sv */
`timescale 1ns/1ps
`default_nettype none
module lbox_file_model (
	// Clock
	input  wire logic                        clock,
	// Read and write ports
	input  wire logic [lbox_pkg::ADDR_W-1:0] raddr,
	output var  logic [lbox_pkg::DATA_W-1:0] rdata,
	input  wire logic                        we,
	input  wire logic [lbox_pkg::ADDR_W-1:0] waddr,
	input  wire logic [lbox_pkg::DATA_W-1:0] wdata
);
	import lbox_pkg::*;
	logic [DATA_W-1:0] mem [0:127];
	// Known fill so the bench can shadow it
	initial for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 5);
	// Same-cycle read; a write lands at the edge ending its strobe
	assign rdata = mem[raddr];
	always @(posedge clock) begin
		if (we) mem[waddr] <= wdata;
	end
endmodule
`default_nettype wire

/* tb/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import lbox_pkg::*;
	logic              clock = 1'b0;
	logic              rst = 1'b1;
	logic              insn_valid = 1'b0;
	logic [INSN_W-1:0] insn = '0;
	logic              insn_done, skip_cycle, file_we, zero_flag;
	logic [ADDR_W-1:0] file_raddr, file_waddr, e_wa, n_wa, a;
	logic [DATA_W-1:0] file_rdata, file_wdata, work_reg, e_w, e_wd, n_wd, t, f;
	logic [DATA_W-1:0] sh [0:127];
	logic [2:0]        b;
	logic [31:0]       r;
	logic              e_z, e_we, e_do, e_sk, n_we, pend;
	int                miscompares = 0;
	int                num_checks = 0;
	int                seed = 32'h3cc3e8e2;
	int                k;
	// Clock
	always #2.5 clock = ~clock;
	lbox_exec i_dut (.clock(clock), .rst(rst), .insn_valid(insn_valid), .insn(insn), .insn_done(insn_done),
		.skip_cycle(skip_cycle), .file_raddr(file_raddr), .file_rdata(file_rdata), .file_we(file_we),
		.file_waddr(file_waddr), .file_wdata(file_wdata), .work_reg(work_reg), .zero_flag(zero_flag));
	lbox_file_model i_file (.clock(clock), .raddr(file_raddr), .rdata(file_rdata), .we(file_we),
		.waddr(file_waddr), .wdata(file_wdata));
	task automatic chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
		num_checks++;
		if (got !== ex) begin
			miscompares++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic report_and_stop;
		if (miscompares == 0 && num_checks > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// Random stream; reads see the file before a write still in flight
	initial begin
		for (int i = 0; i < 128; i++) sh[i] = 8'(i * 37 + 5);
		{e_w, e_z, e_we, e_wa, e_wd, e_do, e_sk, pend, a} = '0;
		repeat (2) @(posedge clock);
		for (int n = 0; n < 4000; n++) begin
			@(negedge clock);
			chk("insn_done", 8'(e_do), 8'(insn_done));
			chk("skip_cycle", 8'(e_sk), 8'(skip_cycle));
			chk("file_we", 8'(e_we), 8'(file_we));
			if (e_we) chk("file_waddr", 8'(e_wa), 8'(file_waddr));
			if (e_we) chk("file_wdata", e_wd, file_wdata);
			chk("work_reg", e_w, work_reg);
			chk("zero_flag", 8'(e_z), 8'(zero_flag));
			chk("file_raddr", 8'(a), 8'(file_raddr));
			rst = (n == 2000);
			insn_valid = pend | (($random(seed) & 7) != 0);
			r = $random(seed);
			k = $unsigned($random(seed)) % 7;
			case (k)
				0: insn = {OP_BIT_CLEAR, r[9:0]};
				1: insn = {OP_BIT_SET, r[9:0]};
				2, 3: insn = {OP_BIT_TEST_CL, r[9:0]};
				4: insn = {OP_AND_LIT, r[7:0]};
				5: insn = {OP_AND_FILE, r[7:0]};
				default: insn = {2'b10, r[11:0]};
			endcase
			a = insn[6:0];
			b = insn[9:7];
			f = sh[a];
			{n_we, n_wa, n_wd, e_do, e_sk} = {1'b0, a, 8'h00, 2'b00};
			if (pend) begin
				e_sk = 1'b1;
				pend = 1'b0;
			end else if (insn_valid) begin
				e_do = 1'b1;
				case (insn[13:10])
					OP_BIT_CLEAR: {n_we, n_wd} = {1'b1, f & ~(8'h01 << b)};
					OP_BIT_SET: {n_we, n_wd} = {1'b1, f | (8'h01 << b)};
					OP_BIT_TEST_CL: pend = !f[b];
					default: begin
						t = e_w & ((insn[13:8] == OP_AND_LIT) ? insn[7:0] : f);
						if (insn[13:8] == OP_AND_LIT || insn[13:8] == OP_AND_FILE) begin
							e_z = (t == 8'h00);
							if (insn[13:8] == OP_AND_FILE && insn[DEST_BIT]) {n_we, n_wd} = {1'b1, t};
							else e_w = t;
						end
					end
				endcase
			end
			if (e_we && !rst) sh[e_wa] = e_wd;
			{e_we, e_wa, e_wd} = {n_we, n_wa, n_wd};
			if (rst) {e_w, e_z, e_we, e_do, e_sk, pend} = '0;
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
